// ### abx_pkg.sv
// shared types and constants for the alu and branch execute block
package abx_pkg;
    localparam int DW = 8;
    localparam int AW = 16;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] SKIP1 = 16'h0002;
    localparam logic [15:0] SKIP2 = 16'h0003;
    localparam logic [2:0] CYC_WORD = 3'h2;
    localparam logic [2:0] CYC_JUMP = 3'h2;
    localparam logic [2:0] CYC_CALL = 3'h4;
    localparam logic [2:0] CYC_RET = 3'h5;
    localparam logic [2:0] CYC_SKIP1 = 3'h2;
    localparam logic [2:0] CYC_SKIP2 = 3'h3;
    localparam logic [2:0] CYC_ONE = 3'h1;
    // flag bit positions inside the flag word
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_I = 7;

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB,
        OP_SUBTRACT_CONSTANT, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW,
        OP_WORD_SUBTRACT_IMMEDIATE, OP_AND, OP_AND_WITH_CONSTANT, OP_OR,
        OP_OR_WITH_CONSTANT, OP_EXCLUSIVE_OR_REGS, OP_SET_MASK_BITS,
        OP_CLEAR_MASK_BITS, OP_TEST_ZERO_MINUS, OP_POINTER_JUMP, OP_POINTER_CALL,
        OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_RETURN, OP_INTERRUPT_RETURN,
        OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE
    } abx_op_e;

    typedef struct packed {
        abx_op_e op;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] rd_hi;
        logic [7:0] imm;
        logic [11:0] offset;
        logic [15:0] pointer;
        logic [15:0] stack_pc;
        logic next_two_words;
    } abx_req_s;

    typedef struct packed {
        logic wr;
        logic wr_word;
        logic [7:0] lo;
        logic [7:0] hi;
    } abx_wb_s;
endpackage : abx_pkg

// ### abx_execute.sv
// alu and branch execute datapath for an 8-bit core
`timescale 1ns/10ps
module abx_execute
    import abx_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire logic REQ_VALID_I,
    input wire abx_req_s REQ_I,
    output logic BUSY_O,
    output logic DONE_O,
    output abx_wb_s WB_O,
    output logic [7:0] FLAGS_O,
    output logic PC_LOAD_O,
    output logic [15:0] PC_O,
    output logic PUSH_O,
    output logic [15:0] RET_ADDR_O
);
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} abx_state_e;

    abx_state_e state_r;
    logic [2:0] cnt_r;
    logic [15:0] pc_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    abx_wb_s wb_nxt;
    logic [15:0] pc_nxt;
    logic pc_load_nxt;
    logic push_nxt;
    logic [2:0] cyc_nxt;

    // byte subtract with borrow-in; flags per 8-bit arithmetic
    function automatic logic [8:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        sub8 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    endfunction : sub8

    function automatic logic [7:0] arith_flags(input logic [7:0] f, input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] r, input logic c, input logic h,
            input logic is_sub);
        logic [7:0] o;
        o = f;
        o[F_Z] = (r == ZERO8);
        o[F_N] = r[7];
        o[F_C] = c;
        o[F_H] = h;
        o[F_V] = is_sub ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])
                        : (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        o[F_S] = o[F_N] ^ o[F_V];
        arith_flags = o;
    endfunction : arith_flags

    function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[F_Z] = (r == ZERO8);
        o[F_N] = r[7];
        o[F_V] = 1'b0;
        o[F_S] = r[7];
        logic_flags = o;
    endfunction : logic_flags

    always_comb begin
        logic [8:0] s;
        logic [16:0] w;
        logic [7:0] b;
        logic [7:0] r;
        logic [15:0] word;
        logic cin;
        logic sub;
        s = 9'h000;
        w = 17'h0_0000;
        b = REQ_I.rr;
        r = ZERO8;
        cin = 1'b0;
        sub = 1'b0;
        word = {REQ_I.rd_hi, REQ_I.rd};
        flags_nxt = flags_r;
        wb_nxt = '0;
        pc_nxt = pc_r;
        pc_load_nxt = 1'b0;
        push_nxt = 1'b0;
        cyc_nxt = CYC_ONE;
        case (REQ_I.op)
            OP_ADD, OP_ADD_CARRY: begin
                cin = (REQ_I.op == OP_ADD_CARRY) & flags_r[F_C];
                s = {1'b0, REQ_I.rd} + {1'b0, REQ_I.rr} + {8'h00, cin};
                r = s[7:0];
                flags_nxt = arith_flags(flags_r, REQ_I.rd, REQ_I.rr, r, s[8],
                    (REQ_I.rd[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & REQ_I.rd[3]), 1'b0);
                wb_nxt = '{wr: 1'b1, wr_word: 1'b0, lo: r, hi: ZERO8};
            end
            OP_SUB, OP_SUBTRACT_CONSTANT, OP_SUBTRACT_WITH_BORROW,
            OP_SUBTRACT_CONSTANT_WITH_BORROW, OP_COMPARE, OP_COMPARE_WITH_CARRY,
            OP_COMPARE_IMMEDIATE: begin
                sub = 1'b1;
                b = (REQ_I.op == OP_SUBTRACT_CONSTANT ||
                     REQ_I.op == OP_SUBTRACT_CONSTANT_WITH_BORROW ||
                     REQ_I.op == OP_COMPARE_IMMEDIATE) ? REQ_I.imm : REQ_I.rr;
                cin = (REQ_I.op == OP_SUBTRACT_WITH_BORROW ||
                       REQ_I.op == OP_SUBTRACT_CONSTANT_WITH_BORROW ||
                       REQ_I.op == OP_COMPARE_WITH_CARRY) & flags_r[F_C];
                s = sub8(REQ_I.rd, b, cin);
                r = s[7:0];
                flags_nxt = arith_flags(flags_r, REQ_I.rd, b, r, s[8],
                    (~REQ_I.rd[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~REQ_I.rd[3]), sub);
                // zero stays sticky only when a borrow comes in from the carry flag; with no borrow it reflects this byte alone
                if (cin) begin
                    flags_nxt[F_Z] = (r == ZERO8) & flags_r[F_Z];
                end
                // compares leave the register file alone
                wb_nxt.wr = !(REQ_I.op == OP_COMPARE || REQ_I.op == OP_COMPARE_WITH_CARRY ||
                              REQ_I.op == OP_COMPARE_IMMEDIATE);
                wb_nxt.lo = r;
            end
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
                sub = (REQ_I.op == OP_WORD_SUBTRACT_IMMEDIATE);
                w = sub ? {1'b0, word} - {9'h000, REQ_I.imm}
                        : {1'b0, word} + {9'h000, REQ_I.imm};
                flags_nxt[F_Z] = (w[15:0] == ZERO16);
                flags_nxt[F_N] = w[15];
                flags_nxt[F_C] = w[16];
                flags_nxt[F_V] = sub ? (word[15] & ~w[15]) : (~word[15] & w[15]);
                flags_nxt[F_S] = w[15] ^ flags_nxt[F_V];
                wb_nxt = '{wr: 1'b1, wr_word: 1'b1, lo: w[7:0], hi: w[15:8]};
                cyc_nxt = CYC_WORD;
            end
            OP_AND, OP_AND_WITH_CONSTANT, OP_TEST_ZERO_MINUS: begin
                b = (REQ_I.op == OP_AND) ? REQ_I.rr :
                    (REQ_I.op == OP_TEST_ZERO_MINUS) ? REQ_I.rd : REQ_I.imm;
                r = REQ_I.rd & b;
                flags_nxt = logic_flags(flags_r, r);
                wb_nxt.wr = (REQ_I.op != OP_TEST_ZERO_MINUS);
                wb_nxt.lo = r;
            end
            OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS, OP_EXCLUSIVE_OR_REGS: begin
                r = (REQ_I.op == OP_EXCLUSIVE_OR_REGS) ? REQ_I.rd ^ REQ_I.rr :
                    (REQ_I.op == OP_OR) ? REQ_I.rd | REQ_I.rr : REQ_I.rd | REQ_I.imm;
                flags_nxt = logic_flags(flags_r, r);
                wb_nxt = '{wr: 1'b1, wr_word: 1'b0, lo: r, hi: ZERO8};
            end
            OP_CLEAR_MASK_BITS: begin
                r = REQ_I.rd & (ALL_ONES - REQ_I.imm);
                flags_nxt = logic_flags(flags_r, r);
                wb_nxt = '{wr: 1'b1, wr_word: 1'b0, lo: r, hi: ZERO8};
            end
            OP_POINTER_JUMP, OP_POINTER_CALL: begin
                pc_nxt = REQ_I.pointer;
                pc_load_nxt = 1'b1;
                push_nxt = (REQ_I.op == OP_POINTER_CALL);
                cyc_nxt = push_nxt ? CYC_CALL : CYC_JUMP;
            end
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
                pc_nxt = pc_r + {{4{REQ_I.offset[11]}}, REQ_I.offset} + ONE16;
                pc_load_nxt = 1'b1;
                push_nxt = (REQ_I.op == OP_RELATIVE_CALL);
                cyc_nxt = push_nxt ? CYC_CALL : CYC_JUMP;
            end
            OP_RETURN, OP_INTERRUPT_RETURN: begin
                pc_nxt = REQ_I.stack_pc;
                pc_load_nxt = 1'b1;
                cyc_nxt = CYC_RET;
                if (REQ_I.op == OP_INTERRUPT_RETURN) begin
                    flags_nxt[F_I] = 1'b1;
                end
            end
            OP_COMPARE_SKIP_EQUAL: begin
                pc_load_nxt = 1'b1;
                if (REQ_I.rd == REQ_I.rr) begin
                    pc_nxt = pc_r + (REQ_I.next_two_words ? SKIP2 : SKIP1);
                    cyc_nxt = REQ_I.next_two_words ? CYC_SKIP2 : CYC_SKIP1;
                end else begin
                    pc_nxt = pc_r + ONE16;
                end
            end
            default: begin
                pc_load_nxt = 1'b0;
            end
        endcase
    end

    // a new request is only taken in idle; multi-cycle ops hold busy
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
        end else if (CE_I) begin
            DONE_O <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (REQ_VALID_I) begin
                        if (cyc_nxt == CYC_ONE) begin
                            DONE_O <= 1'b1;
                        end else begin
                            state_r <= ST_WAIT;
                            cnt_r <= cyc_nxt - CYC_ONE;
                            BUSY_O <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    cnt_r <= cnt_r - 3'h1;
                    if (cnt_r == CYC_ONE) begin
                        state_r <= ST_IDLE;
                        BUSY_O <= 1'b0;
                        DONE_O <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // results and pc update land in the request cycle; done marks the op's last cycle
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WB_O <= '0;
            flags_r <= ZERO8;
            pc_r <= ZERO16;
            PC_LOAD_O <= 1'b0;
            PUSH_O <= 1'b0;
            RET_ADDR_O <= ZERO16;
        end else if (CE_I) begin
            WB_O <= '0;
            PC_LOAD_O <= 1'b0;
            PUSH_O <= 1'b0;
            if (state_r == ST_IDLE && REQ_VALID_I) begin
                WB_O <= wb_nxt;
                flags_r <= flags_nxt;
                PC_LOAD_O <= pc_load_nxt;
                PUSH_O <= push_nxt;
                RET_ADDR_O <= pc_r + ONE16;
                pc_r <= pc_load_nxt ? pc_nxt : pc_r + ONE16;
            end
        end
    end

    assign FLAGS_O = flags_r;
    assign PC_O = pc_r;
endmodule : abx_execute

// ### abx_props.sv
// port assertions for the alu and branch execute block
`timescale 1ns/10ps
module abx_props
    import abx_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    input wire logic REQ_VALID_I,
    input wire abx_req_s REQ_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire abx_wb_s WB_O,
    input wire logic [7:0] FLAGS_O,
    input wire logic PC_LOAD_O,
    input wire logic [15:0] PC_O,
    input wire logic PUSH_O,
    input wire logic [15:0] RET_ADDR_O
);
    // a frozen clock enable stretches every count, so those cycles are not judged
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I || !CE_I);
    logic tk;
    assign tk = CE_I && REQ_VALID_I && !BUSY_O;
    AST_ADD_ONE: assert property (
        tk && REQ_I.op == OP_ADD |=> DONE_O && !BUSY_O && WB_O.wr &&
        WB_O.lo == $past(REQ_I.rd) + $past(REQ_I.rr)) else $error("add wrong");
    AST_WORD_TWO: assert property (
        tk && REQ_I.op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE}
        |=> BUSY_O && WB_O.wr_word ##1 DONE_O && !BUSY_O) else $error("word op wrong");
    AST_PTR_JUMP: assert property (
        tk && REQ_I.op == OP_POINTER_JUMP |=> PC_LOAD_O && PC_O == $past(REQ_I.pointer)
        && $stable(FLAGS_O) ##1 DONE_O && !BUSY_O) else $error("pointer jump wrong");
    AST_CALL: assert property (
        tk && REQ_I.op inside {OP_POINTER_CALL, OP_RELATIVE_CALL} |=> PUSH_O &&
        RET_ADDR_O == $past(PC_O) + ONE16 ##0 BUSY_O[*3] ##1 DONE_O && !BUSY_O)
        else $error("call wrong");
    AST_RET: assert property (
        tk && REQ_I.op inside {OP_RETURN, OP_INTERRUPT_RETURN} |=> PC_O ==
        $past(REQ_I.stack_pc) ##0 BUSY_O[*4] ##1 DONE_O && !BUSY_O) else $error("return wrong");
    AST_IRET_I: assert property (
        tk && REQ_I.op == OP_INTERRUPT_RETURN |=> FLAGS_O[F_I]) else $error("i flag not set");
    AST_CMP: assert property (
        tk && REQ_I.op inside {OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE}
        |=> DONE_O && !WB_O.wr) else $error("compare wrote");
    AST_TEST: assert property (
        tk && REQ_I.op == OP_TEST_ZERO_MINUS |=> !WB_O.wr &&
        FLAGS_O[F_Z] == ($past(REQ_I.rd) == ZERO8)) else $error("test wrong");
    AST_LOGIC: assert property (
        tk && REQ_I.op inside {[OP_AND:OP_TEST_ZERO_MINUS]} |=> !FLAGS_O[F_V] &&
        FLAGS_O[F_C] == $past(FLAGS_O[F_C])) else $error("logic flags wrong");
    AST_SKIP: assert property (
        tk && REQ_I.op == OP_COMPARE_SKIP_EQUAL && REQ_I.rd == REQ_I.rr && REQ_I.next_two_words
        |=> PC_O == $past(PC_O) + SKIP2 ##0 BUSY_O[*2] ##1 DONE_O) else $error("skip wrong");
endmodule : abx_props

// ### abx_partner.sv
// register file and return stack model facing the execute block
`timescale 1ns/10ps
module abx_partner
    import abx_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic take_ret_i,
    input wire abx_wb_s wb_i,
    input wire logic push_i,
    input wire logic [15:0] ret_addr_i,
    output logic [7:0] acc_o,
    output logic [15:0] top_o
);
    logic [7:0] acc_r;
    logic [15:0] stk_r [16];
    logic [3:0] sp_r;
    // write bypass: a back-to-back operation reads the byte just written
    assign acc_o = wb_i.wr ? wb_i.lo : acc_r;
    assign top_o = stk_r[sp_r];
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) acc_r <= ZERO8;
        else if (wb_i.wr) acc_r <= wb_i.lo;
    end
    // stack wraps at sixteen entries, like a small hardware stack
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp_r <= 4'h0;
            for (int i = 0; i < 16; i++) stk_r[i] <= 16'h0100 + 16'(i);
        end else if (push_i) begin
            sp_r <= sp_r + 4'h1;
            stk_r[sp_r + 4'h1] <= ret_addr_i;
        end else if (take_ret_i) sp_r <= sp_r - 4'h1;
    end
endmodule : abx_partner

// ### abx_execute_tb_top.sv
// self-checking bench for the alu and branch execute block
`timescale 1ns/10ps
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", w, e, g); end end
module abx_execute_tb_top
    import abx_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    logic ce = 1'b1;
    abx_req_s req = '0;
    logic busy, done, pc_load, push, take_ret;
    abx_wb_s wb;
    logic [7:0] flags, acc, mf;
    logic [15:0] pc, ret_addr, top, mpc;
    logic [31:0] lf;
    abx_op_e o;
    int errors = 0;
    int n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    assign take_ret = req_valid && !busy && req.op inside {OP_RETURN, OP_INTERRUPT_RETURN};
    abx_execute abx_execute_inst (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .CE_I(ce),
        .REQ_VALID_I(req_valid), .REQ_I(req), .BUSY_O(busy), .DONE_O(done), .WB_O(wb),
        .FLAGS_O(flags), .PC_LOAD_O(pc_load), .PC_O(pc), .PUSH_O(push), .RET_ADDR_O(ret_addr));
    abx_partner abx_partner_inst (.clk_i(clk_sys), .arst_n_i(arst_n), .take_ret_i(take_ret),
        .wb_i(wb), .push_i(push), .ret_addr_i(ret_addr), .acc_o(acc), .top_o(top));
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic alu(abx_op_e op, logic [7:0] b);
        logic [8:0] s;
        logic [7:0] a, f;
        logic cz, cy, ad, wr;
        a = acc;
        f = mf;
        cz = op inside {OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW,
            OP_COMPARE_WITH_CARRY};
        cy = (cz || op == OP_ADD_CARRY) ? mf[F_C] : 1'b0;
        ad = op inside {OP_ADD, OP_ADD_CARRY};
        wr = !(op inside {[OP_COMPARE:OP_COMPARE_IMMEDIATE], OP_TEST_ZERO_MINUS});
        case (op)
            OP_ADD, OP_ADD_CARRY: s = a + b + cy;
            OP_AND, OP_AND_WITH_CONSTANT: s = a & b;
            OP_OR, OP_OR_WITH_CONSTANT, OP_SET_MASK_BITS: s = a | b;
            OP_EXCLUSIVE_OR_REGS: s = a ^ b;
            OP_CLEAR_MASK_BITS: s = a & (ALL_ONES - b);
            OP_TEST_ZERO_MINUS: s = a & a;
            default: s = a - b - cy;
        endcase
        // zero only chains through a borrow that was actually pending
        f[F_Z] = (s[7:0] == ZERO8) && ((cz && cy) ? mf[F_Z] : 1'b1);
        f[F_N] = s[7];
        f[F_V] = 1'b0;
        if (!(op inside {[OP_AND:OP_TEST_ZERO_MINUS]})) begin
            f[F_C] = s[8];
            f[F_V] = (ad ? a[7] == b[7] : a[7] != b[7]) && s[7] != a[7];
            f[F_H] = ad ? 5'(a[3:0]) + 5'(b[3:0]) + cy > 5'h0f : 5'(a[3:0]) < 5'(b[3:0]) + cy;
        end
        f[F_S] = f[F_N] ^ f[F_V];
        req.op = op;
        req.rd = a;
        req.rr = b;
        req.imm = b;
        req_valid = 1'b1;
        @(negedge clk_sys);
        `CHK("done", 1'b1, done)
        `CHK("write", wr, wb.wr)
        if (wr) `CHK("result", s[7:0], wb.lo)
        `CHK("flags", f, flags)
        mf = f;
        mpc = mpc + ONE16;
    endtask : alu
    task automatic br(abx_op_e op, logic [31:0] v);
        logic [16:0] w;
        logic [15:0] ep;
        logic [7:0] ef;
        abx_wb_s ew;
        int n, k;
        logic pu;
        logic pl;
        ew = '0;
        ef = mf;
        ep = mpc + ONE16;
        n = 2;
        pu = 1'b0;
        req = '{op, acc, v[0] ? acc : v[15:8], v[23:16], {2'b00, v[13:8]}, v[27:16],
            v[31:16], top, v[1]};
        case (op)
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE: begin
                w = (op == OP_WORD_ADD_IMMEDIATE) ? {1'b0, req.rd_hi, acc} + req.imm
                    : {1'b0, req.rd_hi, acc} - req.imm;
                ew = '{1'b1, 1'b1, w[7:0], w[15:8]};
                ef[F_C] = w[16];
                ef[F_Z] = w[15:0] == ZERO16;
                ef[F_N] = w[15];
                ef[F_V] = (op == OP_WORD_ADD_IMMEDIATE) ? !req.rd_hi[7] && w[15]
                    : req.rd_hi[7] && !w[15];
                ef[F_S] = w[15] ^ ef[F_V];
            end
            OP_POINTER_JUMP: ep = req.pointer;
            OP_POINTER_CALL: begin ep = req.pointer; n = 4; pu = 1'b1; end
            OP_RELATIVE_JUMP: ep = mpc + {{4{v[27]}}, v[27:16]} + ONE16;
            OP_RELATIVE_CALL: begin ep = mpc + {{4{v[27]}}, v[27:16]} + ONE16; n = 4; pu = 1'b1; end
            OP_RETURN: begin ep = top; n = 5; end
            OP_INTERRUPT_RETURN: begin ep = top; n = 5; ef[F_I] = 1'b1; end
            default: if (acc == req.rr) begin
                ep = mpc + (v[1] ? SKIP2 : SKIP1);
                n = v[1] ? 3 : 2;
            end else n = 1;
        endcase
        pl = !(op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE});
        req_valid = 1'b1;
        @(negedge clk_sys);
        // a compare-skip that does not skip is already done here, so the next request may follow at once
        if (done !== 1'b1) req_valid = 1'b0;
        `CHK("busy", n > 1, busy)
        `CHK("pc load", pl, pc_load)
        `CHK("push", pu, push)
        if (pu) `CHK("return address", mpc + ONE16, ret_addr)
        `CHK("writeback", ew, {wb.wr, wb.wr_word, ew.wr ? {wb.lo, wb.hi} : ZERO16})
        `CHK("pc", ep, pc)
        `CHK("flags", ef, flags)
        for (k = 1; k < 9 && done !== 1'b1; k++) @(negedge clk_sys);
        `CHK("cycles", n, k)
        mpc = ep;
        mf = ef;
    endtask : br
    initial begin
        #500000;
        errors++;
        give_verdict();
    end
    initial begin
        lf = 32'h0000_4ee2;
        mf = ZERO8;
        mpc = ZERO16;
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        for (int i = 0; i < 400; i++) begin
            // freeze the block for a few cycles: nothing may move while the enable is low
            if (i % 50 == 25) begin
                req_valid = 1'b0;
                ce = 1'b0;
                repeat (3) @(negedge clk_sys);
                `CHK("frozen pc", mpc, pc)
                `CHK("frozen flags", mf, flags)
                ce = 1'b1;
            end
            lf = lfsr(lf);
            o = abx_op_e'(lf[4:0] % 5'd27);
            if (o inside {[OP_ADD:OP_TEST_ZERO_MINUS], [OP_COMPARE:OP_COMPARE_IMMEDIATE]} &&
                !(o inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE}))
                alu(o, lf[15:8]);
            else if (o != OP_NOP)
                br(o, lf);
        end
        give_verdict();
    end
endmodule : abx_execute_tb_top
bind abx_execute abx_props abx_props_inst (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
    .CE_I(CE_I), .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .WB_O(WB_O), .FLAGS_O(FLAGS_O), .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O), .PUSH_O(PUSH_O),
    .RET_ADDR_O(RET_ADDR_O));
